// file: rie_pkg.sv
/*
 Shared constants for the rotary interval and wake-event logic:
 register offsets, field positions, reset values and angle figures.
 Assumes every user references names as rie_pkg::name.
*/
package rie_pkg;
   // Register offsets on the 8-bit register port
   localparam logic [7:0] ADDR_FLAGS = 8'h14;
   localparam logic [7:0] ADDR_INDEX = 8'h18;
   localparam logic [7:0] ADDR_ROT = 8'h70;
   localparam logic [7:0] ADDR_PRELOAD = 8'h7C;
   localparam logic [7:0] ADDR_DIVIDER = 8'h7D;
   localparam logic [7:0] ADDR_OFS_LO = 8'h7E;
   localparam logic [7:0] ADDR_OFS_HI = 8'h7F;
   localparam logic [7:0] ADDR_MOVE = 8'h8F;
   localparam logic [7:0] ADDR_SYS = 8'hD0;
   localparam logic [7:0] ADDR_STREAM = 8'hD9;
   // Rotation settings fields
   localparam int unsigned ROT_TOUCH_BIT = 0;
   localparam int unsigned ROT_INT_DIS_BIT = 3;
   localparam int unsigned ROT_WHEEL_DIS_BIT = 4;
   localparam int unsigned ROT_ZERO_BIT = 5;
   localparam int unsigned ROT_INT_UI_DIS_BIT = 6;
   // System and stream settings fields
   localparam int unsigned SYS_EVENT_BIT = 5;
   localparam int unsigned STREAM_BIT = 5;
   // Movement flag fields
   localparam int unsigned FLAG_MOVE_BIT = 7;
   localparam int unsigned FLAG_DIR_BIT = 6;
   // Wake preload fields: timer in the top five bits, threshold below
   localparam int unsigned PRE_TIMER_LSB = 3;
   localparam int unsigned PRE_THR_MSB = 2;
   // Reset values
   localparam logic [7:0] ROT_RESET = 8'h14;
   localparam logic [7:0] PRELOAD_RESET = 8'hF9;
   localparam logic [7:0] DIVIDER_RESET = 8'h03;
   localparam logic [15:0] OFFSET_RESET = 16'h0000;
   // Angle figures in degrees
   localparam logic [7:0] DIV_MIN = 8'h03;
   localparam logic [7:0] DIV_MAX = 8'hB4;
   localparam logic [10:0] FULL_TURN = 11'h168;
   localparam logic [10:0] TWO_TURN = 11'h2D0;
   localparam logic [15:0] OFFSET_MAX = 16'h0168;
   localparam logic signed [10:0] HALF_TURN = 11'sh0B4;
   localparam logic [7:0] HYST_DEG = 8'h01;
   // Timer value loaded once the wheel is awake
   localparam logic [4:0] WAKE_RELOAD = 5'h1F;
endpackage

// file: rie_move_if.sv
/*
 Interface between the interval core and the movement wake unit.
 Assumes both ends share CORE_CLK; no clocking block is used.
*/
`timescale 1ns/1ps
`default_nettype none
interface rie_move_if;
   logic sample;        // One sensing cycle completed
   logic [7:0] mag;     // Degrees moved this cycle
   logic dir;           // Direction of this cycle's move
   logic [4:0] preload; // Timer preload field
   logic [2:0] thr;     // Counter threshold field
   logic hit;           // Counter beat the timer, one cycle
   logic flag;          // Movement flag
   logic flag_dir;      // Direction flag
   logic [4:0] timer;   // Live timer
   // Core end drives the sample
   modport core (output sample, mag, dir, preload, thr,
                 input hit, flag, flag_dir, timer);
   // Wake unit end
   modport wake (input sample, mag, dir, preload, thr,
                 output hit, flag, flag_dir, timer);
endinterface
`default_nettype wire

// file: rie_wake.sv
/*
 Movement wake unit: accumulates degrees moved and counts a timer
 down once per sensing cycle. Assumes samples are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module rie_wake (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Link to the interval core
   rie_move_if.wake mv
);
   // All state of the unit
   typedef struct packed {
      logic [7:0] count;
      logic [4:0] timer;
      logic hit;
      logic flag;
      logic flag_dir;
   } rie_wake_type;

   rie_wake_type st;
   rie_wake_type next_st;
   logic [8:0] sum;     // Counter plus this move
   logic reached;       // Threshold met this cycle

   assign sum = 9'(st.count) + 9'(mv.mag);
   assign reached = (sum >= 9'(mv.thr)) && (sum != 9'h000);

   // Next state per sensing cycle
   always_comb begin
      next_st = st;
      next_st.hit = 1'b0;
      if (mv.sample) begin
         next_st.flag = 1'b0;
         if (reached && (mv.preload == 5'h00 || st.timer != 5'h00)) begin
            next_st.hit = 1'b1;
            next_st.flag = 1'b1;
            next_st.flag_dir = mv.dir;
            next_st.count = 8'h00;
            next_st.timer = mv.preload;
         end else if (mv.preload != 5'h00 && st.timer == 5'h00) begin
            // Window ran out: restart without waking
            next_st.count = 8'h00;
            next_st.timer = mv.preload;
         end else begin
            // Saturate so a long slow turn cannot wrap
            next_st.count = sum[8] ? 8'hFF : sum[7:0];
            next_st.timer = (st.timer != 5'h00) ? st.timer - 5'h01 : 5'h00;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign mv.hit = st.hit;
   assign mv.flag = st.flag;
   assign mv.flag_dir = st.flag_dir;
   assign mv.timer = st.timer;

   a_hit_cause: assert property (@(posedge clk) disable iff (!rst_n)
      st.hit |-> $past(mv.sample) && $past(reached)
         && ($past(mv.preload) == 5'h00 || $past(st.timer) != 5'h00))
      else $error("movement hit without threshold inside window");
   a_expiry_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      mv.sample && !reached |=> !st.hit && !st.flag)
      else $error("movement flagged below threshold");
endmodule // rie_wake
`default_nettype wire

// file: rie_top.sv
/*
 Interval and wake-event logic of a magnetic rotary angle sensor.
 Assumes a filtered angle 0..359 with a one-cycle sample pulse per
 sensing cycle, and a register port driven by a synchronous master.
*/
// Our own choice: the strobed register port.
// Overview of operation
// - Interval size 3..180 degrees, default 3
// - Index register steps once per boundary crossing
// - Index change raises an interval event
// - Zero bit zeroes angle, then clears itself
// - Rotation bit 3 disables interval events
// - Offset 0..360 added before boundaries
// - One degree hysteresis in rotation direction
// - Wake if counter beats preload timer
// - Threshold sets movement event and flags
// - Zero preload wakes on threshold; reload 31
// - Touch source: wake, ready while touched
// - Interval source: wake and ready on change
// - Interval plus wheel selects wheel events
// - Wheel source also readies in low power
// - Stream bit streams in normal mode only
// - No source selected, no wheel events
// - Event mode readies only on events, unless the stream bit is set in normal power
// - Streaming mode readies every sensing cycle
// - Angle input is filtered 0..359 degrees
`timescale 1ns/1ps
`default_nettype none
module rie_top (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // Sensing inputs
   input wire logic [15:0] ANGLE,
   input wire logic SAMPLE,
   input wire logic TOUCH,
   input wire logic LOW_POWER,
   // Event outputs
   output logic READY,
   output logic WAKE_REQ
);
   // All state of the core
   typedef struct packed {
      logic [7:0] index;
      logic [7:0] zone;
      logic [7:0] rot;
      logic [7:0] preload;
      logic [7:0] divider;
      logic [15:0] offset;
      logic [8:0] zero_ref;
      logic [8:0] last;
      logic event_mode;
      logic stream;
      logic int_pend;
      logic samp_d;
      logic ready;
      logic wake;
      logic [7:0] rdata;
   } rie_core_type;

   rie_core_type st;
   rie_core_type next_st;
   rie_move_if mv ();

   logic [7:0] size;         // Clamped interval size
   logic [8:0] ang;          // Angle in degrees
   logic [8:0] ofs;          // Clamped offset
   logic [10:0] rel;         // Angle after zero and offset
   logic [10:0] adj11;       // Reduced to one turn
   logic [8:0] adj;          // Adjusted angle 0..359
   logic [7:0] raw;          // Zone before hysteresis
   logic [7:0] nint;         // Zones per turn
   logic [15:0] prod;        // Start angle of raw zone
   logic [7:0] resid;        // Degrees past raw zone start
   logic [7:0] fwd;          // Forward zone distance
   logic step_up;
   logic step_dn;
   logic signed [10:0] dlt_raw;
   logic signed [10:0] dlt;  // Move, wrapped to half a turn
   logic src_touch;
   logic src_wheel;
   logic src_int;
   logic any_src;
   logic ev;
   logic wr_index;           // Host writes the index

   assign size = (st.divider < rie_pkg::DIV_MIN) ? rie_pkg::DIV_MIN :
                 (st.divider > rie_pkg::DIV_MAX) ? rie_pkg::DIV_MAX : st.divider;
   assign ang = ANGLE[8:0];
   assign ofs = (st.offset > rie_pkg::OFFSET_MAX) ?
                rie_pkg::OFFSET_MAX[8:0] : st.offset[8:0];

   // Adjusted angle and raw zone
   always_comb begin
      rel = 11'(ang) + rie_pkg::FULL_TURN - 11'(st.zero_ref) + 11'(ofs);
      // Always below three turns above zero, so two steps suffice
      if (rel >= rie_pkg::TWO_TURN) begin
         adj11 = rel - rie_pkg::TWO_TURN;
      end else if (rel >= rie_pkg::FULL_TURN) begin
         adj11 = rel - rie_pkg::FULL_TURN;
      end else begin
         adj11 = rel;
      end
      adj = adj11[8:0];
      raw = 8'(adj / 9'(size));
      nint = 8'((rie_pkg::FULL_TURN + 11'(size) - 11'h001) / 11'(size));
      prod = 16'(raw) * 16'(size);
      resid = 8'(16'(adj) - prod);
   end

   // Direction toward the raw zone, shortest way round
   always_comb begin
      fwd = (raw >= st.zone) ? raw - st.zone : 8'(raw + nint - st.zone);
      // up only one degree past boundary
      step_up = (fwd != 8'h00) && (fwd <= (nint >> 1))
                && ((fwd != 8'h01) || (resid >= rie_pkg::HYST_DEG));
      // Down needs the angle below the boundary, i.e. one degree under
      step_dn = (fwd != 8'h00) && (fwd > (nint >> 1));
   end

   // Per-cycle movement, wrapped so 359 to 0 counts as one degree
   always_comb begin
      dlt_raw = $signed(11'(ang)) - $signed(11'(st.last));
      if (dlt_raw > rie_pkg::HALF_TURN) begin
         dlt = dlt_raw - $signed(rie_pkg::FULL_TURN);
      end else if (dlt_raw < -rie_pkg::HALF_TURN) begin
         dlt = dlt_raw + $signed(rie_pkg::FULL_TURN);
      end else begin
         dlt = dlt_raw;
      end
   end

   // Event source selection
   always_comb begin
      src_touch = st.rot[rie_pkg::ROT_TOUCH_BIT];
      src_wheel = !src_touch && !st.rot[rie_pkg::ROT_WHEEL_DIS_BIT];
      src_int = !src_touch && !src_wheel && !st.rot[rie_pkg::ROT_INT_DIS_BIT];
      any_src = src_touch || src_wheel || src_int;
      ev = src_touch ? TOUCH : src_wheel ? mv.hit : src_int ? st.int_pend : 1'b0;
   end

   assign wr_index = REG_WR && (REG_ADDR == rie_pkg::ADDR_INDEX);

   // Move unit inputs
   assign mv.sample = SAMPLE;
   assign mv.mag = dlt[10] ? 8'(-dlt) : 8'(dlt);
   assign mv.dir = dlt[10];
   assign mv.preload = st.preload[7:rie_pkg::PRE_TIMER_LSB];
   assign mv.thr = st.preload[rie_pkg::PRE_THR_MSB:0];

   // Next state of the core
   always_comb begin
      next_st = st;
      next_st.ready = 1'b0;
      next_st.wake = 1'b0;
      next_st.rdata = 8'h00;
      next_st.samp_d = SAMPLE;
      if (SAMPLE) begin
         next_st.last = ang;
      end
      // Stale zone after a size change: resync without stepping
      if (st.zone >= nint) begin
         next_st.zone = raw;
      end else if (SAMPLE && !st.rot[rie_pkg::ROT_INT_UI_DIS_BIT]) begin
         if (step_up) begin
            next_st.zone = (st.zone == nint - 8'h01) ? 8'h00 : st.zone + 8'h01;
            next_st.index = st.index + 8'h01;
         end else if (step_dn) begin
            next_st.zone = (st.zone == 8'h00) ? nint - 8'h01 : st.zone - 8'h01;
            next_st.index = st.index - 8'h01;
         end
      end
      if (st.rot[rie_pkg::ROT_ZERO_BIT]) begin
         next_st.zero_ref = ang;
         next_st.zone = 8'h00;
         next_st.index = 8'h00;
         next_st.rot[rie_pkg::ROT_ZERO_BIT] = 1'b0;
      end
      // Ready and wake decision once the move unit has answered
      if (st.samp_d) begin
         if (!st.event_mode) begin
            next_st.ready = 1'b1;
         end else if (LOW_POWER) begin
            next_st.ready = src_wheel && mv.hit;
            next_st.wake = ev;
         end else begin
            next_st.ready = (st.stream && any_src) || ev;
         end
         if (mv.hit && mv.preload == 5'h00) begin
            next_st.preload[7:rie_pkg::PRE_TIMER_LSB] = rie_pkg::WAKE_RELOAD;
         end
      end
      // Register writes win over the hardware for that register
      if (REG_WR) begin
         case (REG_ADDR)
            rie_pkg::ADDR_INDEX: next_st.index = REG_WDATA;
            rie_pkg::ADDR_ROT: next_st.rot = REG_WDATA;
            rie_pkg::ADDR_PRELOAD: next_st.preload = REG_WDATA;
            rie_pkg::ADDR_DIVIDER: next_st.divider = REG_WDATA;
            rie_pkg::ADDR_OFS_LO: next_st.offset[7:0] = REG_WDATA;
            rie_pkg::ADDR_OFS_HI: next_st.offset[15:8] = REG_WDATA;
            rie_pkg::ADDR_SYS: next_st.event_mode = REG_WDATA[rie_pkg::SYS_EVENT_BIT];
            rie_pkg::ADDR_STREAM: next_st.stream = REG_WDATA[rie_pkg::STREAM_BIT];
            default: next_st.index = next_st.index;
         endcase
      end
      // event on index change; set beats the consuming clear
      next_st.int_pend = (st.int_pend && !st.samp_d)
                         || (next_st.index != st.index);
      // Read data stand for exactly one cycle; unmapped reads give zero
      if (REG_RD) begin
         case (REG_ADDR)
            rie_pkg::ADDR_FLAGS: begin
               next_st.rdata[rie_pkg::FLAG_MOVE_BIT] = mv.flag;
               next_st.rdata[rie_pkg::FLAG_DIR_BIT] = mv.flag_dir;
            end
            rie_pkg::ADDR_INDEX: next_st.rdata = st.index;
            rie_pkg::ADDR_ROT: next_st.rdata = st.rot;
            rie_pkg::ADDR_PRELOAD: next_st.rdata = st.preload;
            rie_pkg::ADDR_DIVIDER: next_st.rdata = st.divider;
            rie_pkg::ADDR_OFS_LO: next_st.rdata = st.offset[7:0];
            rie_pkg::ADDR_OFS_HI: next_st.rdata = st.offset[15:8];
            rie_pkg::ADDR_MOVE: next_st.rdata = 8'(mv.timer);
            rie_pkg::ADDR_SYS: next_st.rdata[rie_pkg::SYS_EVENT_BIT] = st.event_mode;
            rie_pkg::ADDR_STREAM: next_st.rdata[rie_pkg::STREAM_BIT] = st.stream;
            default: next_st.rdata = 8'h00;
         endcase
      end
   end

   // State register with constant reset values
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         st <= '0;
         st.rot <= rie_pkg::ROT_RESET;
         st.preload <= rie_pkg::PRELOAD_RESET;
         st.divider <= rie_pkg::DIVIDER_RESET;
         st.offset <= rie_pkg::OFFSET_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Movement counter and timer
   rie_wake u_wake (
      .clk(CORE_CLK),
      .rst_n(RSTN),
      .mv(mv)
   );

   // Outputs straight from the state register
   assign REG_RDATA = st.rdata;
   assign READY = st.ready;
   assign WAKE_REQ = st.wake;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);

   a_size_range: assert property (
      size >= 8'h03 && size <= 8'hB4 && (st.divider inside {[8'h03:8'hB4]} -> size == st.divider))
      else $error("interval size outside 3 to 180");
   a_index_step: assert property (
      $changed(st.index) && !$past(wr_index) && !$past(st.rot[5])
      |-> st.index == $past(st.index) + 8'h01 || st.index == $past(st.index) - 8'h01)
      else $error("interval index jumped by more than one");
   a_change_event: assert property (
      $changed(st.index) |-> st.int_pend)
      else $error("index change without pending event");
   a_zero_clear: assert property (
      REG_WR && REG_ADDR == rie_pkg::ADDR_ROT && REG_WDATA[rie_pkg::ROT_ZERO_BIT] ##1 !REG_WR
      |-> st.rot[rie_pkg::ROT_ZERO_BIT] ##1 !st.rot[rie_pkg::ROT_ZERO_BIT]
         && st.index == 8'h00 && st.zero_ref == $past(ang))
      else $error("zero bit not acted on and cleared");
   a_hyst_up: assert property (
      SAMPLE && st.zone < nint && fwd == 8'h01 && resid == 8'h00 && !step_dn
      && !st.rot[5] && !wr_index |=> $stable(st.index))
      else $error("interval stepped up on the boundary itself");
   a_reload_31: assert property (
      st.samp_d && mv.hit && mv.preload == 5'h00 && !REG_WR |=> st.preload[7:3] == 5'h1F)
      else $error("timer field not reloaded after wake");
   a_touch_ready: assert property (
      st.samp_d && st.event_mode && !LOW_POWER && st.rot[0] && TOUCH |=> READY)
      else $error("touch did not raise ready");
   a_wheel_prio: assert property (
      st.samp_d && st.event_mode && !st.stream && !st.rot[0] && !st.rot[4] && !mv.hit
      |=> !READY)
      else $error("interval event raised while wheel events selected");
   a_low_power: assert property (
      st.samp_d && st.event_mode && LOW_POWER && !mv.hit |=> !READY)
      else $error("ready streamed in low power");
   a_no_source: assert property (
      st.samp_d && st.event_mode && st.rot[0] == 1'b0 && st.rot[4] && st.rot[3] |=> !READY)
      else $error("ready with every source disabled");
   a_stream_ready: assert property (
      st.samp_d && !st.event_mode |=> READY ##1 !READY || $past(SAMPLE, 2))
      else $error("streaming mode missed a ready");
   a_event_only: assert property (
      READY |-> $past(st.samp_d))
      else $error("ready outside a sensing cycle");

   // Ready is a pulse; samples come at least two cycles apart
   a_ready_pulse: assert property (
      READY |=> !READY)
      else $error("ready held for two cycles");
   // Wake requests belong to low power event mode only
   a_wake_low: assert property (
      WAKE_REQ |-> $past(LOW_POWER) && $past(st.event_mode) && $past(st.samp_d))
      else $error("wake request outside low power event mode");
   // A pending interval change must reach the host in normal power
   a_int_ready: assert property (
      st.samp_d && st.event_mode && !LOW_POWER && src_int && st.int_pend |=> READY)
      else $error("interval change did not raise ready");
   // A wheel hit in low power both wakes and readies
   a_wheel_wake: assert property (
      st.samp_d && st.event_mode && LOW_POWER && src_wheel && mv.hit |=> READY && WAKE_REQ)
      else $error("wheel hit in low power did not wake");

   c_interval_ready: cover property (st.int_pend && st.samp_d ##1 READY);
   c_wheel_wake: cover property (LOW_POWER && mv.hit ##1 WAKE_REQ);
   c_zero: cover property (st.rot[5] ##1 !st.rot[5]);
   c_wrap_down: cover property (step_dn && st.zone == 8'h00 && SAMPLE);
   c_stream_normal: cover property (st.stream && st.samp_d && !LOW_POWER ##1 READY);
endmodule // rie_top
`default_nettype wire

// file: rie_host.sv
/*
 Host controller model for the register port of the interval logic.
 Assumes the device answers a read one cycle later and never stalls.
*/
`timescale 1ns/1ps
`default_nettype none
module rie_host (
   // Clock
   input wire logic CORE_CLK,
   // Register port towards the device
   output logic [7:0] REG_ADDR,
   output logic [7:0] REG_WDATA,
   output logic REG_WR,
   output logic REG_RD
);
   // Idle bus at time zero
   initial begin
      REG_ADDR = 8'h00;
      REG_WDATA = 8'h00;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
   end
   // One-cycle write; released lines show inverted values, not stale ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
      REG_ADDR <= ~a;
      REG_WDATA <= ~d;
   endtask
   // One-cycle read; data is collected by the caller a cycle later
   task automatic rd(input logic [7:0] a);
      @(posedge CORE_CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CORE_CLK);
      REG_RD <= 1'b0;
      REG_ADDR <= ~a;
   endtask
   task automatic sel(input logic [1:0] k);
      case (k)
         2'h0: wr(rie_pkg::ADDR_ROT, 8'h1D);
         2'h1: wr(rie_pkg::ADDR_ROT, 8'h14);
         default: wr(rie_pkg::ADDR_ROT, 8'h0C);
      endcase
   endtask
   task automatic event_mode();
      wr(rie_pkg::ADDR_SYS, 8'h20);
   endtask
endmodule // rie_host
`default_nettype wire

// file: test_rotary_interval_event_logic.sv
/*
 Self-checking bench for the interval and wake-event logic.
 Assumes rie_pkg, rie_move_if, rie_wake, rie_top and rie_host are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_rotary_interval_event_logic;
   logic core_clk = 1'b0; // 50 MHz clock
   logic rstn = 1'b0; // Active low reset
   logic [15:0] angle = 16'h0000; // Filtered angle
   logic sample = 1'b0; // Sensing cycle pulse
   logic touch = 1'b0; // Touch on first_sense_channel
   logic low_power = 1'b0; // Power mode level
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, ready, wake_req;
   logic [3:0] exp_evt[$]; // {check ready, ready, check wake, wake}
   logic [7:0] exp_rd[$]; // Expected read data
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   logic rd_d = 1'b0; // Read strobe seen last edge
   logic [1:0] hist = 2'h0; // Sample pulses of the last two edges
   logic [3:0] e;
   int unsigned r;

   // Free-running clock
   always #10 core_clk = ~core_clk;

   rie_host i_rie_host (.CORE_CLK(core_clk), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd));
   rie_top i_rie_top (.CORE_CLK(core_clk), .RSTN(rstn), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .ANGLE(angle), .SAMPLE(sample), .TOUCH(touch), .LOW_POWER(low_power),
      .READY(ready), .WAKE_REQ(wake_req));

   // Single comparison point
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Read with its expected data noted first
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      exp_rd.push_back(x);
      i_rie_host.rd(a);
   endtask

   // One sensing cycle; spacing keeps pulses well apart
   task automatic smp(input logic [15:0] a, input logic [3:0] x);
      exp_evt.push_back(x);
      @(posedge core_clk);
      angle <= a;
      sample <= 1'b1;
      @(posedge core_clk);
      sample <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic tdone(input string s);
      $display("Test %s done", s);
   endtask

   // Monitor: read data one edge after the strobe, events two edges after a sample
   always @(posedge core_clk) begin
      if (rd_d) begin
         check(reg_rdata, exp_rd.pop_front());
      end
      if (hist[1]) begin
         e = exp_evt.pop_front();
         if (e[3]) check({7'h00, ready}, {7'h00, e[2]});
         if (e[1]) check({7'h00, wake_req}, {7'h00, e[0]});
      end
      rd_d <= reg_rd;
      hist <= {hist[0], sample};
   end

   // Hang guard, well above the expected run length
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         miscompares++;
         end_of_test();
      end
   end

   initial begin
      r = $urandom(32'h0CE5);
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      // reset values and an unmapped address
      rd(rie_pkg::ADDR_DIVIDER, 8'h03);
      rd(rie_pkg::ADDR_ROT, rie_pkg::ROT_RESET);
      rd(rie_pkg::ADDR_PRELOAD, rie_pkg::PRELOAD_RESET);
      rd(rie_pkg::ADDR_OFS_LO, 8'h00);
      rd(rie_pkg::ADDR_OFS_HI, 8'h00);
      rd(rie_pkg::ADDR_INDEX, 8'h00);
      rd(8'h55, 8'h00);
      tdone("reset");
      // streaming readies every cycle, any angle
      for (int i = 0; i < 6; i++) begin
         smp(16'($urandom_range(359, 0)), 4'hC);
      end
      tdone("streaming");
      // zero bit clears itself and the index
      i_rie_host.event_mode();
      i_rie_host.wr(rie_pkg::ADDR_DIVIDER, 8'h24);
      rd(rie_pkg::ADDR_DIVIDER, 8'h24);
      @(posedge core_clk);
      angle <= 16'h0000;
      i_rie_host.wr(rie_pkg::ADDR_ROT, 8'h34);
      repeat (2) @(posedge core_clk);
      rd(rie_pkg::ADDR_ROT, 8'h14);
      rd(rie_pkg::ADDR_INDEX, 8'h00);
      tdone("zero");
      // boundary 36 holds, 37 steps up, 35 steps down
      smp(16'd10, 4'h0);
      smp(16'd10, 4'h8);
      smp(16'd36, 4'h8);
      smp(16'd37, 4'hC);
      rd(rie_pkg::ADDR_INDEX, 8'h01);
      smp(16'd36, 4'h8);
      smp(16'd35, 4'hC);
      rd(rie_pkg::ADDR_INDEX, 8'h00);
      tdone("hysteresis");
      // no source selected, index moves but no ready
      i_rie_host.wr(rie_pkg::ADDR_ROT, 8'h1C);
      smp(16'd37, 4'h8);
      rd(rie_pkg::ADDR_INDEX, 8'h01);
      smp(16'd35, 4'h8);
      // Interval UI disable freezes the index and raises nothing
      i_rie_host.wr(rie_pkg::ADDR_ROT, 8'h54);
      smp(16'd37, 4'h8);
      rd(rie_pkg::ADDR_INDEX, 8'h00);
      tdone("disabled");
      // offset 18 shifts the boundary to angle 18, so 19 steps up
      i_rie_host.sel(2'h1);
      i_rie_host.wr(rie_pkg::ADDR_OFS_LO, 8'h12);
      rd(rie_pkg::ADDR_OFS_LO, 8'h12);
      smp(16'd17, 4'h0);
      smp(16'd17, 4'h8);
      smp(16'd19, 4'hC);
      rd(rie_pkg::ADDR_INDEX, 8'h01);
      smp(16'd17, 4'hC);
      tdone("offset");
      // touch source readies while touched only
      i_rie_host.sel(2'h0);
      @(posedge core_clk);
      touch <= 1'b1;
      smp(16'd17, 4'hC);
      smp(16'd17, 4'hC);
      touch <= 1'b0;
      smp(16'd17, 4'h8);
      tdone("touch");
      // interval change in low power wakes without ready
      i_rie_host.sel(2'h1);
      @(posedge core_clk);
      low_power <= 1'b1;
      smp(16'd19, 4'hB);
      rd(rie_pkg::ADDR_INDEX, 8'h01);
      tdone("low power interval");
      // wheel source, zero timer, threshold 2, readies in low power
      i_rie_host.sel(2'h2);
      i_rie_host.wr(rie_pkg::ADDR_PRELOAD, 8'h02);
      smp(16'd19, 4'h0);
      smp(16'd19, 4'hA);
      smp(16'd24, 4'hF);
      // timer preload reloaded with 31 once awake
      rd(rie_pkg::ADDR_PRELOAD, 8'hFA);
      rd(rie_pkg::ADDR_FLAGS, 8'h80);
      tdone("wheel");
      // stream bit readies in normal power, stops in low power
      @(posedge core_clk);
      low_power <= 1'b0;
      i_rie_host.sel(2'h1);
      i_rie_host.wr(rie_pkg::ADDR_STREAM, 8'h20);
      smp(16'd24, 4'h0);
      smp(16'd24, 4'hC);
      smp(16'd24, 4'hC);
      low_power <= 1'b1;
      smp(16'd24, 4'h8);
      tdone("stream");
      repeat (4) @(posedge core_clk);
      end_of_test();
   end
endmodule // test_rotary_interval_event_logic
`default_nettype wire
